/* mac_defines.svh */
/*
 Offsets, field positions, reset values and widths for the 16 by 16
 multiplier-accumulator. Assumes inclusion by bare name from one folder.
*/
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH

`define MAC_OPND_W 16
`define MAC_ACC_W 35
`define MAC_EXT_W 3
`define MAC_ROUND_BIT 15

`define MAC_OFS_CTRL 8'h00
`define MAC_OFS_STROBE 8'h04
`define MAC_OFS_OPERANDS 8'h08
`define MAC_OFS_LOW 8'h0c
`define MAC_OFS_HIGH 8'h10
`define MAC_OFS_EXT 8'h14
`define MAC_OFS_CONTROLS 8'h18

`define MAC_CTRL_PIN_EN_BIT 0
`define MAC_CTRL_RESET 1'h1
`define MAC_STB_A_BIT 0
`define MAC_STB_B_BIT 1
`define MAC_STB_R_BIT 2

`define MAC_SYNC_W 62
// Drive controls idle high so the pins float until they are synchronised
`define MAC_SYNC_RESET 62'h0000000000000007

`endif

/* mac_pkg.sv */
/*
 Types shared by the multiplier-accumulator files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package mac_pkg;
	typedef enum logic [1:0] {
		MAC_OP_LOAD,
		MAC_OP_ADD,
		MAC_OP_SUB
	} mac_op_t;
endpackage
`default_nettype wire

/* mac_product.sv */
/*
 Combinational 16 by 16 product, optional rounding, extension to the
 accumulator width. Assumes registered operands and controls.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mac_defines.svh"

module mac_product #(
	parameter int OPND_W = `MAC_OPND_W,
	parameter int ACC_W = `MAC_ACC_W
) (
	input wire logic [OPND_W-1:0] opnd_a,
	input wire logic [OPND_W-1:0] opnd_b,
	input wire logic signed_select,
	input wire logic round_control,
	output logic [ACC_W-1:0] product_ext
);
	logic [ACC_W-1:0] a_ext;
	logic [ACC_W-1:0] b_ext;
	logic [ACC_W-1:0] full;
	logic [ACC_W-1:0] round_add;

	always_comb begin
		// Sign fill only for two's complement operands
		a_ext = {{(ACC_W-OPND_W){signed_select & opnd_a[OPND_W-1]}}, opnd_a};
		b_ext = {{(ACC_W-OPND_W){signed_select & opnd_b[OPND_W-1]}}, opnd_b};
		// Product of extended operands is exact; sign extended when signed, zero extended when not
		full = ACC_W'(a_ext * b_ext);
		round_add = '0;
		round_add[OPND_W-1] = round_control;
		product_ext = ACC_W'(full + round_add);
	end
endmodule // mac_product

`default_nettype wire

/* mac_accumulator.sv */
/*
 Multiplier-accumulator core with pin-side clocks sampled in the mclk
 domain and an AHB-Lite register slave. Assumes the pin clocks run well
 below half of mclk and that data settles before each pin clock rises.
*/
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mac_defines.svh"

module mac_accumulator #(
	parameter int OPND_W = `MAC_OPND_W,
	parameter int ACC_W = `MAC_ACC_W,
	parameter int EXT_W = `MAC_EXT_W
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_a_pin,
	input wire logic clk_b_pin,
	input wire logic clk_r_pin,
	input wire logic [OPND_W-1:0] a_in,
	input wire logic [OPND_W-1:0] b_low_in,
	output logic [OPND_W-1:0] low_out,
	output logic low_oe,
	input wire logic [OPND_W-1:0] high_in,
	output logic [OPND_W-1:0] high_out,
	output logic high_oe,
	input wire logic [EXT_W-1:0] ext_in,
	output logic [EXT_W-1:0] ext_out,
	output logic ext_oe,
	input wire logic round_control,
	input wire logic signed_select,
	input wire logic sum_mode_select,
	input wire logic negate_select,
	input wire logic load_from_pins,
	input wire logic ext_word_drive_n,
	input wire logic high_word_drive_n,
	input wire logic low_word_drive_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	logic [`MAC_SYNC_W-1:0] sync1_reg;
	logic [`MAC_SYNC_W-1:0] sync2_reg;
	logic s_clk_a, s_clk_b, s_clk_r;
	logic [OPND_W-1:0] s_a, s_b, s_high;
	logic [EXT_W-1:0] s_ext;
	logic s_round, s_signed, s_sum, s_neg, s_load;
	logic s_ext_dn, s_high_dn, s_low_dn;
	logic a_prev_reg, b_prev_reg, r_prev_reg, or_prev_reg;
	logic pin_en_reg;
	logic [2:0] strobe_reg;
	logic ev_a, ev_b, ev_r, ev_ctl;
	logic [OPND_W-1:0] opnd_a_reg, opnd_b_reg;
	logic round_reg, signed_reg, sum_reg, neg_reg;
	logic [ACC_W-1:0] product_ext;
	logic [ACC_W-1:0] acc_reg, acc_next, arith;
	mac_pkg::mac_op_t op;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic addr_take;

	// Decode of the accumulate operation from the held controls
	function automatic mac_pkg::mac_op_t op_decode(input logic sum,
		input logic neg);
		if (!sum) begin
			op_decode = mac_pkg::MAC_OP_LOAD;
		end else if (neg) begin
			op_decode = mac_pkg::MAC_OP_SUB;
		end else begin
			op_decode = mac_pkg::MAC_OP_ADD;
		end
	endfunction

	// Edge seen only while pin clocks are enabled
	function automatic logic pin_rise(input logic en, input logic now,
		input logic prev);
		pin_rise = en & now & ~prev;
	endfunction

	// A section never drives and preloads at once
	function automatic logic sect_preload(input logic load,
		input logic drive_n);
		sect_preload = load & drive_n;
	endfunction

	function automatic logic sect_drive(input logic load,
		input logic drive_n);
		sect_drive = ~load & ~drive_n;
	endfunction

	// Two stages for every pin; clocks and data stay aligned
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= `MAC_SYNC_RESET;
			sync2_reg <= `MAC_SYNC_RESET;
		end else begin
			sync1_reg <= {clk_a_pin, clk_b_pin, clk_r_pin, a_in, b_low_in,
				high_in, ext_in, round_control, signed_select,
				sum_mode_select, negate_select, load_from_pins,
				ext_word_drive_n, high_word_drive_n, low_word_drive_n};
			sync2_reg <= sync1_reg;
		end
	end

	assign {s_clk_a, s_clk_b, s_clk_r, s_a, s_b, s_high, s_ext, s_round,
		s_signed, s_sum, s_neg, s_load, s_ext_dn, s_high_dn,
		s_low_dn} = sync2_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_prev_reg <= 1'b0;
			b_prev_reg <= 1'b0;
			r_prev_reg <= 1'b0;
			or_prev_reg <= 1'b0;
		end else begin
			a_prev_reg <= s_clk_a;
			b_prev_reg <= s_clk_b;
			r_prev_reg <= s_clk_r;
			or_prev_reg <= s_clk_a | s_clk_b;
		end
	end

	// Software strobes act like pin clock edges; pin edges can be masked
	// Pin clock pulses shorter than one mclk period may be missed
	always_comb begin
		ev_a = pin_rise(pin_en_reg, s_clk_a, a_prev_reg) |
			strobe_reg[`MAC_STB_A_BIT];
		ev_b = pin_rise(pin_en_reg, s_clk_b, b_prev_reg) |
			strobe_reg[`MAC_STB_B_BIT];
		ev_r = pin_rise(pin_en_reg, s_clk_r, r_prev_reg) |
			strobe_reg[`MAC_STB_R_BIT];
		ev_ctl = pin_rise(pin_en_reg, s_clk_a | s_clk_b, or_prev_reg) |
			strobe_reg[`MAC_STB_A_BIT] | strobe_reg[`MAC_STB_B_BIT];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			opnd_a_reg <= '0;
		end else if (ev_a) begin
			opnd_a_reg <= s_a;
		end
	end

	// B shares the low word pins; B is taken whatever drives them
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			opnd_b_reg <= '0;
		end else if (ev_b) begin
			opnd_b_reg <= s_b;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			round_reg <= 1'b0;
			signed_reg <= 1'b0;
			sum_reg <= 1'b0;
			neg_reg <= 1'b0;
		end else if (ev_ctl) begin
			round_reg <= s_round;
			signed_reg <= s_signed;
			sum_reg <= s_sum;
			neg_reg <= s_neg;
		end
	end

	mac_product #(
		.OPND_W(OPND_W),
		.ACC_W(ACC_W)
	) u_product (
		.opnd_a(opnd_a_reg),
		.opnd_b(opnd_b_reg),
		.signed_select(signed_reg),
		.round_control(round_reg),
		.product_ext(product_ext)
	);

	// R sharing an edge with A or B still sees the old operands
	always_comb begin
		op = op_decode(sum_reg, neg_reg);
		case (op)
			mac_pkg::MAC_OP_ADD: arith = ACC_W'(acc_reg + product_ext);
			mac_pkg::MAC_OP_SUB: arith = ACC_W'(product_ext - acc_reg);
			mac_pkg::MAC_OP_LOAD: arith = product_ext;
			default: arith = product_ext;
		endcase
		acc_next = arith;
		// Each section preloads on its own; others take the result
		if (sect_preload(s_load, s_low_dn)) begin
			acc_next[OPND_W-1:0] = s_b;
		end
		if (sect_preload(s_load, s_high_dn)) begin
			acc_next[2*OPND_W-1:OPND_W] = s_high;
		end
		if (sect_preload(s_load, s_ext_dn)) begin
			acc_next[ACC_W-1:2*OPND_W] = s_ext;
		end
	end

	// Cleared at reset only so that outputs are known; pins never reset it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_reg <= '0;
		end else if (ev_r) begin
			acc_reg <= acc_next;
		end
	end

	// Enables follow the synced pins, two cycles behind
	always_comb begin
		low_out = acc_reg[OPND_W-1:0];
		high_out = acc_reg[2*OPND_W-1:OPND_W];
		ext_out = acc_reg[ACC_W-1:2*OPND_W];
		low_oe = sect_drive(s_load, s_low_dn);
		high_oe = sect_drive(s_load, s_high_dn);
		ext_oe = sect_drive(s_load, s_ext_dn);
	end

	// Bus slave: zero wait states, always OKAY
	// Sizes are not decoded; every access is taken as a whole word
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_take = hsel & hready & htrans[1];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_take & hwrite;
			if (addr_take) begin
				wr_addr_reg <= haddr;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_en_reg <= `MAC_CTRL_RESET;
		end else if (wr_pend_reg && wr_addr_reg == `MAC_OFS_CTRL) begin
			pin_en_reg <= hwdata[`MAC_CTRL_PIN_EN_BIT];
		end
	end

	// Strobe bits last one cycle and read back as zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strobe_reg <= 3'h0;
		end else if (wr_pend_reg && wr_addr_reg == `MAC_OFS_STROBE) begin
			strobe_reg <= hwdata[2:0];
		end else begin
			strobe_reg <= 3'h0;
		end
	end

	// Read data is latched at the address phase and stands in the data phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hrdata_reg <= 32'h00000000;
		end else if (addr_take && !hwrite) begin
			case (haddr)
				`MAC_OFS_CTRL: hrdata_reg <= {31'h00000000, pin_en_reg};
				`MAC_OFS_OPERANDS: hrdata_reg <= {opnd_b_reg, opnd_a_reg};
				`MAC_OFS_LOW: hrdata_reg <= {16'h0000, acc_reg[OPND_W-1:0]};
				`MAC_OFS_HIGH:
					hrdata_reg <= {16'h0000, acc_reg[2*OPND_W-1:OPND_W]};
				`MAC_OFS_EXT:
					hrdata_reg <= {29'h00000000, acc_reg[ACC_W-1:2*OPND_W]};
				`MAC_OFS_CONTROLS:
					hrdata_reg <= {28'h0000000, neg_reg, sum_reg, signed_reg,
						round_reg};
				default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end
endmodule // mac_accumulator

`default_nettype wire

/* mac_acc_props.sv */
/*
 Port checker for the multiplier-accumulator.
 Assumes a bind onto mac_accumulator and the single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mac_acc_props (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_r_pin,
	input wire logic [15:0] b_low_in,
	input wire logic [15:0] low_out,
	input wire logic low_oe,
	input wire logic [15:0] high_out,
	input wire logic high_oe,
	input wire logic [2:0] ext_out,
	input wire logic ext_oe,
	input wire logic load_from_pins,
	input wire logic ext_word_drive_n,
	input wire logic high_word_drive_n,
	input wire logic low_word_drive_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("hresp not OKAY");
	a_ready_high: assert property (hreadyout == 1'h1)
		else $error("hreadyout low");
	a_low_drive: assert property (($stable(low_word_drive_n)
		&& $stable(load_from_pins))[*4]
		|-> low_oe == (!low_word_drive_n && !load_from_pins))
		else $error("low_oe wrong");
	a_high_drive: assert property (($stable(high_word_drive_n)
		&& $stable(load_from_pins))[*4]
		|-> high_oe == (!high_word_drive_n && !load_from_pins))
		else $error("high_oe wrong");
	a_ext_drive: assert property (($stable(ext_word_drive_n)
		&& $stable(load_from_pins))[*4]
		|-> ext_oe == (!ext_word_drive_n && !load_from_pins))
		else $error("ext_oe wrong");
	// Bus writes may strobe a result event, so they break the window
	a_sum_hold: assert property ((!clk_r_pin
		&& !(hsel && htrans[1] && hwrite))[*5]
		|-> $stable({ext_out, high_out, low_out}))
		else $error("sum moved without result clock");
	a_read_zero: assert property ((hsel && hready && htrans[1] && !hwrite
		&& (haddr == 8'h04 || haddr > 8'h18)) |=> hrdata == 32'h0)
		else $error("unmapped or strobe read not zero");
	a_low_preload: assert property (($rose(clk_r_pin)
		&& load_from_pins && low_word_drive_n)
		|-> ##[2:4] low_out == $past(b_low_in, 2))
		else $error("low word not preloaded");
	cover property ($rose(low_oe));
	cover property ($rose(clk_r_pin) && load_from_pins);
	cover property (hsel && htrans[1] && hwrite);
	cover property (hsel && htrans[1] && hwrite && haddr == 8'h04);
endmodule // mac_acc_props
`default_nettype wire

/* mac_host_model.sv */
/*
 Driving logic beside the multiplier-accumulator: operands, controls, clocks.
 Assumes mclk from the bench and the design's low word pins.
*/
`timescale 1ns/1ps
`default_nettype none
module mac_host_model (
	input wire logic mclk,
	input wire logic low_oe,
	input wire logic [15:0] low_out,
	output logic clk_a_pin,
	output logic clk_b_pin,
	output logic clk_r_pin,
	output logic [15:0] a_in,
	output logic [15:0] b_low_in,
	output logic round_control,
	output logic signed_select,
	output logic sum_mode_select,
	output logic negate_select
);
	logic [15:0] b_drv;
	// Host lets go of the shared pins while the device drives them
	assign b_low_in = low_oe ? low_out : b_drv;
	initial begin
		{clk_a_pin, clk_b_pin, clk_r_pin} = 3'h0;
		a_in = 16'h0;
		b_drv = 16'h0;
		{negate_select, sum_mode_select, signed_select, round_control} = 4'h0;
	end
	task automatic res;
		repeat (3) @(posedge mclk);
		clk_r_pin <= 1'h1;
		repeat (3) @(posedge mclk);
		clk_r_pin <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask
	// Controls are {negate, sum, signed, round}
	task automatic op(input logic [15:0] a, input logic [15:0] b,
		input logic [3:0] c);
		@(posedge mclk);
		a_in <= a;
		b_drv <= b;
		{negate_select, sum_mode_select, signed_select, round_control} <= c;
		// Two cycles of setup, three of hold, slower than the sync
		repeat (2) @(posedge mclk);
		clk_a_pin <= 1'h1;
		clk_b_pin <= 1'h1;
		repeat (3) @(posedge mclk);
		clk_a_pin <= 1'h0;
		clk_b_pin <= 1'h0;
		res();
	endtask
endmodule // mac_host_model
`default_nettype wire

/* mac_16x16_accumulator_tb.sv */
/*
 Bench for the multiplier-accumulator: host model on the pins, AHB-Lite tasks.
 Assumes the design files and checker compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module mac_16x16_accumulator_tb;
	logic mclk = 1'h0, nrst, clk_a_pin, clk_b_pin, clk_r_pin, low_oe, high_oe;
	logic ext_oe, round_control, signed_select, sum_mode_select;
	logic negate_select, load_from_pins, ext_word_drive_n, high_word_drive_n;
	logic low_word_drive_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [15:0] a_in, b_low_in, low_out, high_in, high_out;
	logic [2:0] ext_in, ext_out, hsize;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	int err_count = 0, checks_done = 0;
	always #12.5 mclk = ~mclk;
	assign hready = hreadyout;
	mac_accumulator i_mac_accumulator (.mclk(mclk), .nrst(nrst),
		.clk_a_pin(clk_a_pin), .clk_b_pin(clk_b_pin), .clk_r_pin(clk_r_pin),
		.a_in(a_in), .b_low_in(b_low_in), .low_out(low_out), .low_oe(low_oe),
		.high_in(high_in), .high_out(high_out), .high_oe(high_oe),
		.ext_in(ext_in), .ext_out(ext_out), .ext_oe(ext_oe),
		.round_control(round_control), .signed_select(signed_select),
		.sum_mode_select(sum_mode_select), .negate_select(negate_select),
		.load_from_pins(load_from_pins),
		.ext_word_drive_n(ext_word_drive_n),
		.high_word_drive_n(high_word_drive_n),
		.low_word_drive_n(low_word_drive_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata));
	mac_host_model i_mac_host_model (.mclk(mclk), .low_oe(low_oe),
		.low_out(low_out), .clk_a_pin(clk_a_pin), .clk_b_pin(clk_b_pin),
		.clk_r_pin(clk_r_pin), .a_in(a_in), .b_low_in(b_low_in),
		.round_control(round_control), .signed_select(signed_select),
		.sum_mode_select(sum_mode_select), .negate_select(negate_select));
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge mclk);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'h1, 2'h2, a, wr, 3'h2};
		do @(posedge mclk); while (hreadyout !== 1'h1);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, wd};
		do @(posedge mclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic acc_is(input logic [34:0] e);
		`CHK("acc", e, {ext_out, high_out, low_out})
	endtask
	task automatic stop_test;
		$display("Mismatches %0d of %0d checks", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		err_count++;
		stop_test();
	end
	initial begin
		{nrst, hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
		{load_from_pins, high_in, ext_in} = '0;
		{ext_word_drive_n, high_word_drive_n, low_word_drive_n} = 3'h7;
		repeat (6) @(posedge mclk);
		nrst <= 1'h1;
		ahb(1'h0, 8'h00, 32'h0);
		`CHK("ctrl", 32'h1, rd)
		ahb(1'h0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		i_mac_host_model.op(16'hfffd, 16'h0005, 4'h2);
		acc_is(35'h7_ffff_fff1);
		ahb(1'h0, 8'h08, 32'h0);
		`CHK("operands", 32'h0005_fffd, rd)
		ahb(1'h0, 8'h18, 32'h0);
		`CHK("controls", 32'h2, rd)
		i_mac_host_model.op(16'hffff, 16'hffff, 4'h0);
		acc_is(35'h0_fffe_0001);
		i_mac_host_model.op(16'hffff, 16'hffff, 4'h4);
		acc_is(35'h1_fffc_0002);
		i_mac_host_model.op(16'hffff, 16'hffff, 4'hc);
		acc_is(35'h7_0001_ffff);
		i_mac_host_model.op(16'hfffd, 16'h0005, 4'h6);
		acc_is(35'h7_0001_fff0);
		i_mac_host_model.op(16'h0002, 16'h0003, 4'h8);
		acc_is(35'h0_0000_0006);
		i_mac_host_model.op(16'h0001, 16'h8000, 4'h1);
		ahb(1'h0, 8'h10, 32'h0);
		`CHK("rounded", 32'h1, rd)
		{ext_word_drive_n, high_word_drive_n, low_word_drive_n} <= 3'h0;
		repeat (5) @(posedge mclk);
		`CHK("oe", 3'h7, {ext_oe, high_oe, low_oe})
		`CHK("shared", 16'h0000, b_low_in)
		{ext_word_drive_n, high_word_drive_n, low_word_drive_n} <= 3'h7;
		{load_from_pins, high_in, ext_in} <= {1'h1, 16'h1234, 3'h5};
		i_mac_host_model.b_drv <= 16'habcd;
		i_mac_host_model.res();
		acc_is(35'h5_1234_abcd);
		`CHK("oe", 3'h0, {ext_oe, high_oe, low_oe})
		low_word_drive_n <= 1'h0;
		i_mac_host_model.op(16'h0002, 16'h0003, 4'h8);
		acc_is(35'h5_1234_0006);
		{load_from_pins, low_word_drive_n} <= 2'h1;
		ahb(1'h1, 8'h00, 32'h0);
		i_mac_host_model.op(16'h0007, 16'h0007, 4'h0);
		acc_is(35'h5_1234_0006);
		ahb(1'h1, 8'h04, 32'h3);
		ahb(1'h1, 8'h04, 32'h4);
		ahb(1'h0, 8'h0c, 32'h0);
		`CHK("low", 32'h31, rd)
		ahb(1'h0, 8'h14, 32'h0);
		`CHK("ext", 32'h0, rd)
		acc_is(35'h0_0000_0031);
		ahb(1'h1, 8'h00, 32'h1);
		stop_test();
	end
endmodule // mac_16x16_accumulator_tb
bind mac_accumulator mac_acc_props i_mac_acc_props (.mclk, .nrst,
	.clk_r_pin, .b_low_in, .low_out, .low_oe, .high_out, .high_oe,
	.ext_out, .ext_oe, .load_from_pins, .ext_word_drive_n,
	.high_word_drive_n, .low_word_drive_n, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata);
`default_nettype wire
